// file: logic/rail_enable_sequencer.sv
/*
 Rail enable sequencer: reads eight delay bytes from the pattern store
 after reset, raises the timing reference, then raises each of eight rail
 enables once its delay in microsecond or millisecond ticks has passed.
 Assumes i_rstn is the push-button reset, i_clock runs at 50 MHz and the
 store image is fixed at build time through DELAY_IMAGE.
*/
// Functional notes
// RQ1 - Two tick domains: 1 kHz and 1 MHz
// RQ2 - Delays are whole ticks of their domain
// RQ3 - Eight enables: four microsecond, four millisecond
// RQ4 - Locations 0-3 microsecond, 4-7 millisecond delays
// RQ5 - Address n drives enable n plus one
// RQ6 - Enable rises after stored count of ticks
// RQ7 - Reference rises as soon as core initialised
// RQ8 - Delays measured from reference, not cumulative
// RQ9 - Ticks divided down from a faster clock
// RQ10 - Paced store reads latched into holding registers
// RQ11 - Address generator feeds separate enable generator
// RQ12 - Enables 1-4 microsecond, 5-8 millisecond clocked
// RQ13 - Base tick 1 MHz, one microsecond spacing
// RQ14 - Ticks from logic dividers, no PLL
// RQ15 - Active-low push-button reset input
// RQ16 - All enables and reference active high
// RQ17 - Store is eight pages of sixteen bytes
// RQ18 - Reset clears all; enables stay high after
`timescale 1ns/10ps
module rail_enable_sequencer #(
    parameter logic [63:0] DELAY_IMAGE = rail_seq_pkg::DEFAULT_IMAGE
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    output logic o_timing_reference,
    output logic o_rail_enable_1,
    output logic o_rail_enable_2,
    output logic o_rail_enable_3,
    output logic o_rail_enable_4,
    output logic o_rail_enable_5,
    output logic o_rail_enable_6,
    output logic o_rail_enable_7,
    output logic o_rail_enable_8
);
    localparam int unsigned NR = rail_seq_pkg::NUM_RAILS;
    localparam int unsigned RDW = $clog2(rail_seq_pkg::READ_DIV + 1);
    localparam logic [RDW-1:0] READ_TOP = RDW'(rail_seq_pkg::READ_DIV - 1);

    // Enable is due once the elapsed tick count has reached the delay
    function automatic logic rail_due(input logic [7:0] count, input logic [7:0] delay);
        rail_due = (count >= delay);
    endfunction : rail_due

    // Saturating tick counter step
    function automatic logic [7:0] count_step(input logic [7:0] count);
        count_step = (count == rail_seq_pkg::COUNT_MAX) ? count : count + 8'h01;
    endfunction : count_step

    rail_seq_pkg::seq_state_t state_q;
    logic [RDW-1:0] read_cnt_q;
    logic read_strobe_q;
    logic [rail_seq_pkg::STORE_AW-1:0] addr_q;
    logic addr_done_q;
    logic [7:0] rd_data_q;
    logic [rail_seq_pkg::STORE_AW-1:0] rd_addr_q;
    logic rd_valid_q;
    logic [7:0] delay_q [0:NR-1];
    logic reference_q;
    logic us_tick;
    logic ms_tick;
    logic [7:0] us_count_q;
    logic [7:0] ms_count_q;
    logic [NR-1:0] rail_q;
    logic [7:0] store_mem [0:rail_seq_pkg::STORE_BYTES-1];

    // Nonvolatile pattern store: eight pages of sixteen bytes, image in the low bytes
    always_comb begin // RQ17
        for (int i = 0; i < rail_seq_pkg::STORE_BYTES; i++) begin
            store_mem[i] = 8'h00;
        end
        for (int i = 0; i < NR; i++) begin
            store_mem[i] = DELAY_IMAGE[8*i +: 8];
        end
    end

    // Read pacing strobe at the read clock rate
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            read_cnt_q <= '0;
            read_strobe_q <= 1'b0;
        end else if (i_clk_en) begin
            if (state_q == rail_seq_pkg::ST_LOAD && !addr_done_q) begin
                read_strobe_q <= (read_cnt_q == READ_TOP); // RQ10
                read_cnt_q <= (read_cnt_q == READ_TOP) ? '0 : read_cnt_q + 1'b1;
            end else begin
                read_strobe_q <= 1'b0;
                read_cnt_q <= '0;
            end
        end
    end

    // Address generator: steps through the eight delay locations once
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_q <= rail_seq_pkg::US_BASE_ADDR;
            addr_done_q <= 1'b0;
        end else if (i_clk_en) begin
            if (read_strobe_q && !addr_done_q) begin // RQ11
                if (addr_q == rail_seq_pkg::LAST_ADDR) begin
                    addr_done_q <= 1'b1;
                end else begin
                    addr_q <= addr_q + 7'h01;
                end
            end
        end
    end

    // Registered store read
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data_q <= 8'h00;
            rd_addr_q <= '0;
            rd_valid_q <= 1'b0;
        end else if (i_clk_en) begin
            rd_valid_q <= read_strobe_q && !addr_done_q;
            if (read_strobe_q && !addr_done_q) begin
                rd_data_q <= store_mem[addr_q]; // RQ10
                rd_addr_q <= addr_q;
            end
        end
    end

    // Holding registers: location n times enable n plus one
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NR; i++) begin
                delay_q[i] <= rail_seq_pkg::DELAY_RESET;
            end
        end else if (i_clk_en) begin
            if (rd_valid_q) begin
                delay_q[rd_addr_q[2:0]] <= rd_data_q; // RQ4 RQ5
            end
        end
    end

    // Core initialised once the last location is held; reference follows at once
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin // RQ15
            state_q <= rail_seq_pkg::ST_LOAD;
            reference_q <= 1'b0;
        end else if (i_clk_en) begin
            unique case (state_q)
                rail_seq_pkg::ST_LOAD: begin
                    if (rd_valid_q && rd_addr_q == rail_seq_pkg::LAST_ADDR) begin
                        state_q <= rail_seq_pkg::ST_RUN;
                        reference_q <= 1'b1; // RQ7 RQ16
                    end
                end
                rail_seq_pkg::ST_RUN: begin
                    reference_q <= 1'b1;
                end
            endcase
        end
    end

    // Tick generation by logic dividers, restarted at the reference
    tick_divider #(
        .DIV(rail_seq_pkg::US_DIV)
    ) u_us_div ( // RQ1 RQ9 RQ13 RQ14
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_clk_en(i_clk_en),
        .i_run(reference_q),
        .i_step(1'b1),
        .o_tick(us_tick)
    );

    tick_divider #(
        .DIV(rail_seq_pkg::MS_DIV)
    ) u_ms_div ( // RQ1 RQ9 RQ14
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_clk_en(i_clk_en),
        .i_run(reference_q),
        .i_step(us_tick),
        .o_tick(ms_tick)
    );

    // Elapsed ticks since the reference, one counter per domain
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            us_count_q <= rail_seq_pkg::COUNT_RESET; // RQ18
            ms_count_q <= rail_seq_pkg::COUNT_RESET;
        end else if (i_clk_en) begin
            if (!reference_q) begin
                us_count_q <= rail_seq_pkg::COUNT_RESET; // RQ8
                ms_count_q <= rail_seq_pkg::COUNT_RESET;
            end else begin
                if (us_tick) begin
                    us_count_q <= count_step(us_count_q); // RQ2
                end
                if (ms_tick) begin
                    ms_count_q <= count_step(ms_count_q); // RQ2
                end
            end
        end
    end

    // Enable generator: each rail compared on its own, sticky until reset
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rail_q <= '0; // RQ18
        end else if (i_clk_en) begin
            if (reference_q) begin
                for (int i = 0; i < NR; i++) begin
                    if (i < rail_seq_pkg::US_RAILS) begin
                        if (rail_due(us_count_q, delay_q[i])) begin
                            rail_q[i] <= 1'b1; // RQ3 RQ6 RQ8 RQ12
                        end
                    end else begin
                        if (rail_due(ms_count_q, delay_q[i])) begin
                            rail_q[i] <= 1'b1; // RQ3 RQ6 RQ8 RQ12
                        end
                    end
                end
            end
        end
    end

    assign o_timing_reference = reference_q;
    assign o_rail_enable_1 = rail_q[0];
    assign o_rail_enable_2 = rail_q[1];
    assign o_rail_enable_3 = rail_q[2];
    assign o_rail_enable_4 = rail_q[3];
    assign o_rail_enable_5 = rail_q[4];
    assign o_rail_enable_6 = rail_q[5];
    assign o_rail_enable_7 = rail_q[6];
    assign o_rail_enable_8 = rail_q[7];

    // Checks
    property p_ref_after_load;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(reference_q) |-> $past(rd_valid_q) && ($past(rd_addr_q) == 7'h07);
    endproperty
    a_ref_after_load: assert property (p_ref_after_load) // RQ7
        else $error("reference rose without last store location held");

    property p_rail_sticky;
        @(posedge i_clock) disable iff (!i_rstn)
        &(rail_q | ~$past(rail_q));
    endproperty
    a_rail_sticky: assert property (p_rail_sticky) // RQ18
        else $error("rail enable dropped without reset");

    property p_no_rail_before_ref;
        @(posedge i_clock) disable iff (!i_rstn)
        (rail_q != 8'h00) |-> reference_q;
    endproperty
    a_no_rail_before_ref: assert property (p_no_rail_before_ref) // RQ8
        else $error("rail enable ahead of reference");

    property p_counts_held;
        @(posedge i_clock) disable iff (!i_rstn)
        !reference_q |-> (us_count_q == 8'h00) && (ms_count_q == 8'h00);
    endproperty
    a_counts_held: assert property (p_counts_held) // RQ8
        else $error("tick counters ran before reference");

    property p_rail1_exact;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(rail_q[0]) |-> $past(us_count_q) == delay_q[0];
    endproperty
    a_rail1_exact: assert property (p_rail1_exact) // RQ5
        else $error("enable 1 rose at wrong microsecond count");

    property p_rail5_exact;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(rail_q[4]) |-> $past(ms_count_q) == delay_q[4];
    endproperty
    a_rail5_exact: assert property (p_rail5_exact) // RQ4
        else $error("enable 5 rose at wrong millisecond count");

    property p_ms_from_us;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(ms_tick) |-> $past(us_tick);
    endproperty
    a_ms_from_us: assert property (p_ms_from_us) // RQ1
        else $error("millisecond tick not aligned to microsecond tick");

    property p_count_on_tick;
        @(posedge i_clock) disable iff (!i_rstn)
        reference_q && $changed(us_count_q) |-> $past(us_tick) && $past(i_clk_en);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) // RQ2
        else $error("microsecond count moved without a tick");

    property p_read_pace;
        @(posedge i_clock) disable iff (!i_rstn)
        (read_strobe_q && i_clk_en) |=> !read_strobe_q;
    endproperty
    a_read_pace: assert property (p_read_pace) // RQ10
        else $error("store reads faster than the read clock");

    property p_freeze;
        @(posedge i_clock) disable iff (!i_rstn)
        !i_clk_en |=> $stable(rail_q) && $stable(us_count_q) && $stable(state_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    property p_cov_ref;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(reference_q);
    endproperty
    c_cov_ref: cover property (p_cov_ref);

    property p_cov_us_rail;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(rail_q[3]);
    endproperty
    c_cov_us_rail: cover property (p_cov_us_rail);

    property p_cov_all_rails;
        @(posedge i_clock) disable iff (!i_rstn)
        $rose(&rail_q);
    endproperty
    c_cov_all_rails: cover property (p_cov_all_rails);

endmodule : rail_enable_sequencer

// file: logic/rail_seq_pkg.sv
/*
 Constants for the rail enable sequencer: clock rates, tick dividers,
 pattern store layout and the default delay image.
 Assumes a single 50 MHz system clock; every tick is derived from it.
*/
package rail_seq_pkg;

    // System clock
    localparam int unsigned CLOCK_HZ = 50_000_000;

    // Tick domains
    localparam int unsigned US_TICK_HZ = 1_000_000;
    localparam int unsigned MS_TICK_HZ = 1_000;
    localparam int unsigned US_DIV = CLOCK_HZ / US_TICK_HZ;
    localparam int unsigned MS_DIV = US_TICK_HZ / MS_TICK_HZ;

    // Store read pacing: one read per period of the 20 MHz read clock, rounded up
    localparam int unsigned READ_CLOCK_HZ = 20_000_000;
    localparam int unsigned READ_DIV = (CLOCK_HZ + READ_CLOCK_HZ - 1) / READ_CLOCK_HZ;

    // Pattern store layout
    localparam int unsigned STORE_PAGES = 8;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned STORE_BYTES = STORE_PAGES * PAGE_BYTES;
    localparam int unsigned STORE_AW = $clog2(STORE_BYTES);

    // Rails and their store locations
    localparam int unsigned NUM_RAILS = 8;
    localparam int unsigned US_RAILS = 4;
    localparam logic [6:0] US_BASE_ADDR = 7'h00;
    localparam logic [6:0] MS_BASE_ADDR = 7'h04;
    localparam logic [6:0] LAST_ADDR = 7'h07;

    // Reset values and counter saturation limit
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    // Default delay image, byte 0 in the low lane
    localparam logic [63:0] DEFAULT_IMAGE = {
        8'h09, 8'h03, 8'h06, 8'h01, 8'h26, 8'h0F, 8'h14, 8'h05
    };

    typedef enum logic [0:0] {
        ST_LOAD = 1'b0,
        ST_RUN = 1'b1
    } seq_state_t;

endpackage : rail_seq_pkg

// file: logic/tick_divider.sv
/*
 Tick divider: emits a one-cycle tick every DIV steps while running.
 Assumes i_step comes from logic on the same clock; held clear while
 i_run is low so the first tick falls a full period after the start.
*/
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned DIV = 50
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire logic i_run,
    input wire logic i_step,
    output logic o_tick
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] TOP = CW'(DIV - 1);

    logic [CW-1:0] count_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= '0;
            o_tick <= 1'b0;
        end else if (i_clk_en) begin
            if (!i_run) begin
                count_q <= '0;
                o_tick <= 1'b0;
            end else if (i_step) begin
                o_tick <= (count_q == TOP);
                count_q <= (count_q == TOP) ? '0 : count_q + 1'b1;
            end else begin
                o_tick <= 1'b0;
            end
        end
    end

endmodule : tick_divider

// file: testbench/regulator_model.sv
/*
 Regulator bank model: records, per rail, how many clock cycles after the
 timing reference rose its enable was first seen high, and flags an enable
 that drops or rises before the reference.
 Assumes enables change on rising edges; it samples on falling edges.
*/
`timescale 1ns/10ps
module regulator_model (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_reference,
    input wire logic [7:0] i_enables,
    output int o_rise_cycle [8],
    output logic o_fault
);
    int cnt;
    logic started;

    // Offsets are counted in every cycle, with or without the clock enable
    always @(negedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt = 0;
            started = 1'b0;
            o_fault = 1'b0;
            for (int n = 0; n < 8; n++) o_rise_cycle[n] = -1;
        end else begin
            if (i_reference === 1'b1) begin
                if (started) cnt = cnt + 1;
                started = 1'b1;
            end
            for (int n = 0; n < 8; n++) begin
                if (i_enables[n] === 1'b1 && o_rise_cycle[n] == -1) o_rise_cycle[n] = cnt;
                if (i_enables[n] !== 1'b1 && o_rise_cycle[n] != -1) o_fault = 1'b1;
                if (i_enables[n] === 1'b1 && !started) o_fault = 1'b1;
            end
        end
    end
endmodule : regulator_model

// file: testbench/testbench.sv
/*
 Self-checking bench for the rail enable sequencer with a short delay
 image; checks reset, load time, freeze, mid-run reset and all offsets.
 Assumes the 50 MHz clock and the regulator model beside the design.
*/
`timescale 1ns/10ps
module testbench;
    localparam logic [63:0] IMAGE = {8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h02};
    localparam int TIMEOUT = 60000;
    logic i_clock;
    logic i_rstn;
    logic i_clk_en;
    logic o_timing_reference;
    logic [7:0] rails;
    int rise [8];
    logic fault;
    int error_cnt;
    int n_compared;
    int cycles;

    rail_enable_sequencer #(.DELAY_IMAGE(IMAGE)) DUT (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
        .o_timing_reference(o_timing_reference),
        .o_rail_enable_1(rails[0]), .o_rail_enable_2(rails[1]),
        .o_rail_enable_3(rails[2]), .o_rail_enable_4(rails[3]),
        .o_rail_enable_5(rails[4]), .o_rail_enable_6(rails[5]),
        .o_rail_enable_7(rails[6]), .o_rail_enable_8(rails[7])
    );

    regulator_model regulators (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_reference(o_timing_reference),
        .i_enables(rails), .o_rise_cycle(rise), .o_fault(fault)
    );

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    always @(posedge i_clock) begin
        cycles++;
        if (cycles >= TIMEOUT) begin
            error_cnt++;
            $display("mismatch timeout expected %0d seen %0d", TIMEOUT - 1, cycles);
            final_report();
        end
    end

    task automatic check_vec(input string name, input logic [8:0] expected, input logic [8:0] seen);
        n_compared++;
        if (seen !== expected) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, expected, seen);
        end
    endtask : check_vec

    task automatic check_int(input string name, input int expected, input int seen);
        n_compared++;
        if (seen != expected) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", name, expected, seen);
        end
    endtask : check_int

    // Offset of rail n from the reference, all cycles enabled
    function automatic int expected_offset(input int n);
        int d;
        d = int'(IMAGE[8 * n +: 8]);
        if (d == 0) return 1;
        if (n < rail_seq_pkg::US_RAILS) return rail_seq_pkg::US_DIV * d + 2;
        // Millisecond tick is registered one cycle after the microsecond tick it counts
        return rail_seq_pkg::US_DIV * rail_seq_pkg::MS_DIV * d + 3;
    endfunction : expected_offset

    task automatic release_and_wait(output int edges);
        edges = 0;
        @(posedge i_clock);
        #1 i_rstn = 1'b1;
        while (o_timing_reference !== 1'b1 && edges < 100) begin
            @(posedge i_clock);
            #1 edges++;
        end
    endtask : release_and_wait

    task automatic check_reset_state();
        check_vec("outputs in reset", 9'h000, {o_timing_reference, rails});
    endtask : check_reset_state

    task automatic check_load_and_freeze();
        int edges;
        release_and_wait(edges);
        check_int("reference edge", 26, edges);
        i_clk_en = 1'b0;
        repeat (20) @(posedge i_clock);
        #1 check_vec("frozen outputs", 9'h100, {o_timing_reference, rails});
        i_clk_en = 1'b1;
        repeat (110) @(posedge i_clock);
        #1 check_int("rail 2 frozen", 21, rise[1]);
        check_int("rail 4 frozen", 72, rise[3]);
        check_int("rail 1 frozen", 122, rise[0]);
        check_vec("rails mid run", 9'h16B, {o_timing_reference, rails});
        check_vec("rail fault before reset", 9'h000, {8'h00, fault});
        i_rstn = 1'b0;
        #1 check_reset_state();
    endtask : check_load_and_freeze

    task automatic check_sequence();
        int edges;
        int waited;
        release_and_wait(edges);
        check_int("reference edge after reset", 26, edges);
        waited = 0;
        while ((rise[4] == -1 || rise[7] == -1) && waited < 51000) begin
            @(posedge i_clock);
            waited++;
        end
        repeat (5) @(posedge i_clock);
        #1 for (int n = 0; n < 8; n++) begin
            check_int($sformatf("rail %0d offset", n + 1), expected_offset(n), rise[n]);
        end
        check_vec("all rails high", 9'h1FF, {o_timing_reference, rails});
        check_vec("rail fault", 9'h000, {8'h00, fault});
    endtask : check_sequence

    initial begin
        error_cnt = 0;
        n_compared = 0;
        cycles = 0;
        i_rstn = 1'b0;
        i_clk_en = 1'b1;
        repeat (2) @(posedge i_clock);
        #1 check_reset_state();
        check_load_and_freeze();
        repeat (2) @(posedge i_clock);
        #1 check_reset_state();
        check_sequence();
        final_report();
    end
endmodule : testbench
